/* design/bmr_boot_mirror.sv */
// Boot sector mirror loader, program address remap, read protection and control register.
// Assumes one 20 MHz clock, an APB master, a flash read port answering with a valid
// strobe, and a program SRAM write port that may stall with its ready.
`timescale 1ns/10ps
`include "bmr_cfg.svh"

// ****************************************************************
// Small FIFO between flash reads and SRAM writes
// ****************************************************************
module bmr_fifo #(
  parameter int WIDTH = 22,
  parameter int DEPTH = 8
) (
  // Clock and control
  input  wire logic             core_clk_in,
  input  wire logic             resetn_in,
  input  wire logic             clk_en_in,
  input  wire logic             flush_in,
  // Fill side
  input  wire logic             in_valid_in,
  output logic                  in_ready_out,
  input  wire logic [WIDTH-1:0] in_data_in,
  // Drain side
  output logic                  out_valid_out,
  input  wire logic             out_ready_in,
  output logic [WIDTH-1:0]      out_data_out
);
  localparam int AW = $clog2(DEPTH);
  initial begin
    if (DEPTH < 2 || (1 << AW) != DEPTH) $error("bmr_fifo: DEPTH must be a power of two");
  end
  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW:0]      wr_q, rd_q;
  logic             push, pop;

  // Full when pointers differ only in the wrap bit
  assign in_ready_out  = (wr_q ^ rd_q) != {1'b1, {AW{1'b0}}};
  assign out_valid_out = wr_q != rd_q;
  assign out_data_out  = mem_q[rd_q[AW-1:0]];
  assign push          = in_valid_in & in_ready_out;
  assign pop           = out_valid_out & out_ready_in;

  // Storage
  always_ff @(posedge core_clk_in) begin
    if (clk_en_in && push) begin
      mem_q[wr_q[AW-1:0]] <= in_data_in;
    end
  end

  // Pointers
  always_ff @(posedge core_clk_in) begin
    if (!resetn_in || (clk_en_in && flush_in)) begin
      wr_q <= '0;
      rd_q <= '0;
    end else if (clk_en_in) begin
      if (push) wr_q <= wr_q + 1'b1;
      if (pop)  rd_q <= rd_q + 1'b1;
    end
  end
endmodule : bmr_fifo

// ****************************************************************
// Top level
// ****************************************************************
// Functional notes
// R1: Bit 7 of the boot sector's top byte is the debugger read protection control.
// R2: A 1 in that bit lets the debug port read flash.
// R3: A 0 in that bit blocks debug port reads of flash.
// R4: The protection bit never affects CPU fetches from flash or mirrored SRAM.
// R5: After reset or reboot the lowest 16K flash bytes are copied to SRAM while the CPU is held.
// R6: Program addresses below 16K are served by SRAM with no wait states.
// R7: The CPU may run from SRAM while flash is being rewritten.
// R8: The copy typically takes a few milliseconds; overrun of that budget is reported.
// R9: Writing 1 to control bit 0 resets CPU and peripherals, and the bit self-clears.
// R10: Writing 1 to control bit 1 reboots the chip, redoes the mirror, reloads EEPROM; self-clears.
// R11: With remap set, program addresses 16K to 32K reach flash 0 to 16K.
// R12: With remap set, program addresses below 16K still reach SRAM.
// R13: With remap clear (reset), program addresses 16K to 32K map straight to flash.
// R14: Software writes 0 to control bit 3; bit 4 always reads 0.
// R15: Bit 5 mirrors the EEPROM boot disable pin.
// R16: Bits 7:6 mirror the two clock select strap pins.
// R17: The CPU is released only after the last SRAM byte is written.
module bmr_boot_mirror
  import bmr_pkg::*;
#(
  parameter int FLASH_AW        = 19,
  parameter int FIFO_DEPTH      = 8,
  parameter int LOAD_BUDGET_CYC = `BMR_LOAD_CYC
) (
  // Clock, reset, enable
  input  wire logic                core_clk_in,
  input  wire logic                resetn_in,
  input  wire logic                clk_en_in,
  // APB slave
  input  wire logic                psel_in,
  input  wire logic                penable_in,
  input  wire logic                pwrite_in,
  input  wire logic [11:0]         paddr_in,
  input  wire logic [31:0]         pwdata_in,
  output logic [31:0]              prdata_out,
  output logic                     pready_out,
  output logic                     pslverr_out,
  // Loader flash read port
  output logic                     ldr_flash_rd_out,
  output logic [13:0]              ldr_flash_addr_out,
  input  wire logic                flash_rvalid_in,
  input  wire logic [7:0]          flash_rdata_in,
  // Program SRAM write port
  output logic                     sram_we_out,
  output logic [13:0]              sram_waddr_out,
  output logic [7:0]               sram_wdata_out,
  input  wire logic                sram_ready_in,
  // CPU program address routing
  input  wire logic [FLASH_AW-1:0] cpu_paddr_in,
  output logic                     cpu_sram_sel_out,
  output logic                     cpu_flash_sel_out,
  output logic [FLASH_AW-1:0]      cpu_flash_addr_out,
  // Debug port gate
  input  wire logic                dbg_flash_rd_in,
  output logic                     dbg_flash_rd_ok_out,
  // Resets and reload
  output logic                     cpu_hold_out,
  output logic                     periph_reset_out,
  output logic                     eeprom_reload_out,
  // Strap pins
  input  wire logic [1:0]          clock_strap_pins_in,
  input  wire logic                eeprom_boot_disable_in
);
  initial begin
    if (FLASH_AW < 16) $error("bmr_boot_mirror: FLASH_AW must cover 32K");
    if (FIFO_DEPTH < 2) $error("bmr_boot_mirror: FIFO_DEPTH too small");
    if (LOAD_BUDGET_CYC < 1) $error("bmr_boot_mirror: LOAD_BUDGET_CYC must be positive");
  end

  localparam int CW = $clog2(LOAD_BUDGET_CYC + 1);

  // State and wiring
  bmr_state_t    st_q;
  logic [13:0]   rd_addr_q;
  logic [CW-1:0] ld_cyc_q;
  logic [1:0]    strap_s1_q, strap_s2_q;
  logic [31:0]   prdata_q;
  logic [21:0]   fifo_out_data;
  logic [7:0]    ctrl_val;
  logic          last_req_q, ld_done_q, ld_slow_q, prot_q, remap_q, rsvd3_q;
  logic          soft_rst_q, soft_rbt_q, skip_s1_q, skip_s2_q, pready_q, perr_q;
  logic          fifo_in_valid, fifo_in_ready, fifo_out_valid, sram_fire;
  logic          ctrl_hit, stat_hit, apb_wr, apb_rd, restart;

  // ****************************************************************
  // Address remap
  // ****************************************************************
  // Route one program address: SRAM below 16K, flash above, 16K to 32K folded when remapped
  function automatic logic [FLASH_AW:0] bmr_map(input logic [FLASH_AW-1:0] a,
                                                input logic remap);
    if (a < FLASH_AW'(`BMR_BOOT_TOP)) return {1'b1, a};       // R6 R12
    if (remap && a < FLASH_AW'(`BMR_REMAP_TOP))
      return {1'b0, a - FLASH_AW'(`BMR_BOOT_TOP)};            // R11
    return {1'b0, a};                                         // R13
  endfunction : bmr_map

  // Fetch routing is purely combinational so SRAM sees no added wait state
  always_comb begin
    logic [FLASH_AW:0] m;
    m = bmr_map(cpu_paddr_in, remap_q);
    cpu_sram_sel_out   = m[FLASH_AW];                         // R6 R7
    cpu_flash_sel_out  = ~m[FLASH_AW];
    cpu_flash_addr_out = m[FLASH_AW-1:0];                     // R4
  end

  // Pin synchronisers: two flops each, and only the second is read
  always_ff @(posedge core_clk_in) begin
    if (!resetn_in) begin
      {strap_s1_q, strap_s2_q, skip_s1_q, skip_s2_q} <= 6'h00;
    end else if (clk_en_in) begin
      {strap_s1_q, skip_s1_q} <= {clock_strap_pins_in, eeprom_boot_disable_in};
      {strap_s2_q, skip_s2_q} <= {strap_s1_q, skip_s1_q};     // R15 R16
    end
  end

  // ****************************************************************
  // APB slave
  // ****************************************************************
  assign ctrl_hit = paddr_in[1:0] == 2'h0 && paddr_in[11:2] == `BMR_CTRL_IDX;
  assign stat_hit = paddr_in[1:0] == 2'h0 && paddr_in[11:2] == `BMR_STAT_IDX;
  assign apb_wr   = clk_en_in & psel_in & penable_in & pready_q & pwrite_in;
  assign apb_rd   = clk_en_in & psel_in & penable_in & ~pready_q;
  assign restart  = soft_rbt_q;

  // Bit 4 reads 0; self-clearing bits read back while still set
  assign ctrl_val = {strap_s2_q, skip_s2_q, 1'b0, rsvd3_q,    // R14 R15 R16
                     remap_q, soft_rbt_q, soft_rst_q};

  // One wait cycle so read data comes from a flop
  always_ff @(posedge core_clk_in) begin
    if (!resetn_in) begin
      pready_q <= 1'b0;
      perr_q   <= 1'b0;
      prdata_q <= 32'h0000_0000;
    end else if (clk_en_in) begin
      pready_q <= apb_rd;
      if (apb_rd) begin
        perr_q   <= ~(ctrl_hit | stat_hit);
        prdata_q <= ctrl_hit ? {24'h00_0000, ctrl_val} :
                    stat_hit ? {28'h000_0000, ld_slow_q, prot_q, ld_done_q, ~ld_done_q} :
                               32'h0000_0000;
      end
    end
  end

  assign pready_out  = pready_q;
  assign pslverr_out = pready_q & perr_q;
  assign prdata_out  = prdata_q;

  // ****************************************************************
  // Control register
  // ****************************************************************
  // A reboot returns the register to its reset value like the rest of the chip
  always_ff @(posedge core_clk_in) begin
    if (!resetn_in) begin
      remap_q    <= 1'(`BMR_CTRL_RESET >> `BMR_REMAP_BIT);
      rsvd3_q    <= 1'b0;
      soft_rst_q <= 1'b0;
      soft_rbt_q <= 1'b0;
    end else if (clk_en_in) begin
      soft_rst_q <= 1'b0;                                     // R9
      soft_rbt_q <= 1'b0;                                     // R10
      if (restart) begin
        remap_q <= 1'b0;                                      // R13
        rsvd3_q <= 1'b0;
      end else if (apb_wr && ctrl_hit && !perr_q) begin
        remap_q    <= pwdata_in[`BMR_REMAP_BIT];              // R11
        rsvd3_q    <= pwdata_in[`BMR_RSVD_RW_BIT];            // R14
        soft_rst_q <= pwdata_in[`BMR_SOFT_RESET_BIT];         // R9
        soft_rbt_q <= pwdata_in[`BMR_SOFT_REBOOT_BIT];        // R10
      end
    end
  end

  // Soft reset and reboot both reset peripherals; only reboot reloads EEPROM
  assign periph_reset_out  = soft_rst_q | soft_rbt_q;         // R9 R10
  assign eeprom_reload_out = soft_rbt_q;                      // R10
  assign cpu_hold_out      = ~ld_done_q | soft_rst_q;         // R5 R9 R17

  // ****************************************************************
  // Loader sequencer
  // ****************************************************************
  assign ldr_flash_rd_out   = st_q == BMR_ST_REQ && fifo_in_ready;
  assign ldr_flash_addr_out = rd_addr_q;
  assign fifo_in_valid      = st_q == BMR_ST_WAIT && flash_rvalid_in;

  // One read outstanding; a request goes out only when the FIFO has room
  always_ff @(posedge core_clk_in) begin
    if (!resetn_in) begin
      st_q       <= BMR_ST_REQ;                               // R5
      rd_addr_q  <= 14'h0000;
      last_req_q <= 1'b0;
    end else if (clk_en_in) begin
      if (restart) begin
        st_q       <= BMR_ST_REQ;                             // R10
        rd_addr_q  <= 14'h0000;
        last_req_q <= 1'b0;
      end else begin
        case (st_q)
          BMR_ST_REQ: begin
            if (fifo_in_ready) begin
              st_q       <= BMR_ST_WAIT;
              last_req_q <= rd_addr_q == 14'(`BMR_BOOT_BYTES - 1);
            end
          end
          BMR_ST_WAIT: begin
            if (flash_rvalid_in) begin
              rd_addr_q <= rd_addr_q + 14'h0001;
              st_q      <= last_req_q ? BMR_ST_DRAIN : BMR_ST_REQ;
            end
          end
          BMR_ST_DRAIN: begin
            if (ld_done_q) begin
              st_q <= BMR_ST_DONE;
            end
          end
          BMR_ST_DONE: st_q <= BMR_ST_DONE;
          default:     st_q <= BMR_ST_REQ;
        endcase
      end
    end
  end

  // Done only once the top byte has actually landed in SRAM
  always_ff @(posedge core_clk_in) begin
    if (!resetn_in) begin
      ld_done_q <= 1'b0;
    end else if (clk_en_in) begin
      if (restart) begin
        ld_done_q <= 1'b0;                                    // R10
      end else if (sram_fire && fifo_out_data[21:8] == `BMR_PROT_ADDR) begin
        ld_done_q <= 1'b1;                                    // R17
      end
    end
  end

  // Budget watch: flags a copy slower than the typical figure, never stops it
  always_ff @(posedge core_clk_in) begin
    if (!resetn_in) begin
      ld_cyc_q  <= '0;
      ld_slow_q <= 1'b0;
    end else if (clk_en_in) begin
      if (restart) begin
        ld_cyc_q  <= '0;
        ld_slow_q <= 1'b0;
      end else if (!ld_done_q) begin
        if (ld_cyc_q == CW'(LOAD_BUDGET_CYC)) begin
          ld_slow_q <= 1'b1;                                  // R8
        end else begin
          ld_cyc_q <= ld_cyc_q + 1'b1;
        end
      end
    end
  end

  // ****************************************************************
  // Data path into SRAM
  // ****************************************************************
  bmr_fifo #(
    .WIDTH (22),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .core_clk_in   (core_clk_in),
    .resetn_in     (resetn_in),
    .clk_en_in     (clk_en_in),
    .flush_in      (restart),
    .in_valid_in   (fifo_in_valid),
    .in_ready_out  (fifo_in_ready),
    .in_data_in    ({rd_addr_q, flash_rdata_in}),
    .out_valid_out (fifo_out_valid),
    .out_ready_in  (sram_ready_in),
    .out_data_out  (fifo_out_data)
  );

  assign sram_we_out    = fifo_out_valid & ~restart;          // R5
  assign sram_waddr_out = fifo_out_data[21:8];
  assign sram_wdata_out = fifo_out_data[7:0];
  assign sram_fire      = sram_we_out & sram_ready_in;

  // ****************************************************************
  // Read protection
  // ****************************************************************
  // Blocked until the boot sector top byte has been seen; cleared on reboot
  always_ff @(posedge core_clk_in) begin
    if (!resetn_in) begin
      prot_q <= 1'b0;
    end else if (clk_en_in) begin
      if (restart) begin
        prot_q <= 1'b0;
      end else if (sram_fire && fifo_out_data[21:8] == `BMR_PROT_ADDR) begin
        prot_q <= fifo_out_data[`BMR_PROT_BIT];               // R1
      end
    end
  end

  // Gates only the debugger; CPU routing above never looks at it
  assign dbg_flash_rd_ok_out = dbg_flash_rd_in & prot_q;      // R2 R3 R4
endmodule : bmr_boot_mirror

/* design/bmr_cfg.svh */
// Constants of the boot mirror and remap controller: offsets, fields, resets, timing.
// Assumes inclusion by bare name from design files; definitions only.
`ifndef BMR_CFG_SVH
`define BMR_CFG_SVH
// Register word indexes; the byte address is four times the index
`define BMR_CTRL_IDX      10'h08F
`define BMR_STAT_IDX      10'h090
`define BMR_CTRL_RESET    8'h00
// Control register fields
`define BMR_SOFT_RESET_BIT   0
`define BMR_SOFT_REBOOT_BIT  1
`define BMR_REMAP_BIT        2
`define BMR_RSVD_RW_BIT      3
`define BMR_RSVD_RO_BIT      4
`define BMR_BOOT_SKIP_BIT    5
`define BMR_CLK_SEL_LSB      6
// Boot sector layout
`define BMR_BOOT_BYTES    16384
`define BMR_PROT_ADDR     14'h3FFF
`define BMR_PROT_BIT      7
`define BMR_BOOT_TOP      19'h04000
`define BMR_REMAP_TOP     19'h08000
// Timing
`define BMR_CLK_MHZ       20
`define BMR_LOAD_TIME_US  4900
`define BMR_LOAD_CYC      (`BMR_LOAD_TIME_US * `BMR_CLK_MHZ)
`endif

/* design/bmr_pkg.sv */
// Types shared by the boot mirror and remap controller.
// Assumes nothing beyond a SystemVerilog compiler.
package bmr_pkg;
  // Loader states, Gray coded along REQ -> WAIT -> DRAIN -> DONE
  typedef enum logic [1:0] {
    BMR_ST_REQ   = 2'b00,
    BMR_ST_WAIT  = 2'b01,
    BMR_ST_DRAIN = 2'b11,
    BMR_ST_DONE  = 2'b10
  } bmr_state_t;
endpackage : bmr_pkg

/* tb/bmr_boot_mirror_chk.sv */
// Checker of register timing, copy order, CPU release and program address routing.
// Assumes binding to bmr_boot_mirror on one clock; sees its ports only.
`timescale 1ns/10ps
`include "bmr_cfg.svh"
module bmr_boot_mirror_chk #(
  parameter int FLASH_AW = 19
) (
  // Clock, reset and register bus
  input wire logic                core_clk_in,
  input wire logic                resetn_in,
  input wire logic                psel_in,
  input wire logic                penable_in,
  input wire logic                pwrite_in,
  input wire logic [11:0]         paddr_in,
  input wire logic [31:0]         pwdata_in,
  input wire logic [31:0]         prdata_out,
  input wire logic                pready_out,
  input wire logic                pslverr_out,
  // Loader and SRAM
  input wire logic                ldr_flash_rd_out,
  input wire logic                sram_we_out,
  input wire logic [13:0]         sram_waddr_out,
  input wire logic                sram_ready_in,
  // CPU side
  input wire logic [FLASH_AW-1:0] cpu_paddr_in,
  input wire logic                cpu_sram_sel_out,
  input wire logic                cpu_flash_sel_out,
  input wire logic [FLASH_AW-1:0] cpu_flash_addr_out,
  input wire logic                cpu_hold_out,
  input wire logic                periph_reset_out,
  input wire logic                eeprom_reload_out
);
  // ****************************************************************
  // Helpers and properties
  // ****************************************************************
  localparam logic [11:0] CTRL_A = {`BMR_CTRL_IDX, 2'b00};
  logic ctrl_acc;
  logic last_wr;
  // A reboot flushes the loader, so copy-order checks skip those cycles
  assign ctrl_acc = psel_in && penable_in && pready_out && pwrite_in && paddr_in == CTRL_A;
  assign last_wr  = sram_we_out && sram_ready_in && sram_waddr_out == 14'h3FFF;
  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (!resetn_in);
  sequence ctrl_wr_s;
    ctrl_acc;
  endsequence
  chk_apb_one_wait: assert property (psel_in && penable_in && !pready_out |=> pready_out)
    else $error("no answer one cycle after the access edge");
  chk_err_read_zero: assert property (pslverr_out && !pwrite_in |-> pready_out && prdata_out == 32'h0)
    else $error("refused read returned data");
  chk_soft_reset: assert property (
    ctrl_wr_s ##0 pwdata_in[0] |=> periph_reset_out && cpu_hold_out ##1 !periph_reset_out)
    else $error("soft reset pulse wrong");
  chk_reboot_pulse: assert property (
    ctrl_wr_s ##0 pwdata_in[1] |=> eeprom_reload_out ##1 !eeprom_reload_out && cpu_hold_out)
    else $error("reboot pulse wrong");
  chk_sram_hold: assert property (
    sram_we_out && !sram_ready_in && !ctrl_acc && !eeprom_reload_out
    |=> sram_we_out && $stable(sram_waddr_out)) else $error("stalled SRAM write dropped");
  chk_sram_order: assert property (
    sram_we_out && sram_ready_in && !last_wr && !ctrl_acc && !eeprom_reload_out
    |=> !sram_we_out || sram_waddr_out == $past(sram_waddr_out) + 14'h1)
    else $error("SRAM write address out of order");
  chk_hold_release: assert property (
    $fell(cpu_hold_out) && !$past(periph_reset_out) |-> $past(last_wr))
    else $error("CPU released before the last byte");
  chk_done_release: assert property (last_wr && !ctrl_acc |=> !cpu_hold_out)
    else $error("CPU not released after the last byte");
  chk_low_sram: assert property (
    cpu_paddr_in < 32'h4000 |-> cpu_sram_sel_out && !cpu_flash_sel_out)
    else $error("low program address not routed to SRAM");
  chk_mid_flash: assert property (
    cpu_paddr_in >= 32'h4000 && cpu_paddr_in < 32'h8000 |-> cpu_flash_sel_out
    && !cpu_sram_sel_out && cpu_flash_addr_out[13:0] == cpu_paddr_in[13:0])
    else $error("middle program address not routed to flash");
  chk_req_single: assert property (
    ldr_flash_rd_out && !ctrl_acc && !eeprom_reload_out |=> !ldr_flash_rd_out)
    else $error("flash read request longer than one cycle");
endmodule : bmr_boot_mirror_chk

bind bmr_boot_mirror bmr_boot_mirror_chk #(.FLASH_AW(FLASH_AW)) chk_u (.*);

/* tb/bmr_far_model.sv */
// Far side of the boot mirror: flash read port and program SRAM write port.
// Assumes the mirror's clock; the bench chooses the protection bit of the top byte.
`timescale 1ns/10ps
module bmr_far_model (
  // Clock, reset, boot sector choice
  input  wire logic        core_clk_in,
  input  wire logic        resetn_in,
  input  wire logic        prot_bit_in,
  // Flash read port
  input  wire logic        flash_rd_in,
  input  wire logic [13:0] flash_addr_in,
  output logic             flash_rvalid_out,
  output logic [7:0]       flash_rdata_out,
  // SRAM write port
  input  wire logic        sram_we_in,
  input  wire logic [13:0] sram_waddr_in,
  input  wire logic [7:0]  sram_wdata_in,
  output logic             sram_ready_out
);
  logic [7:0]  sram_mem [0:16383];
  logic [13:0] addr_q;
  logic [1:0]  wait_q;
  logic        busy_q;
  logic [2:0]  stall_q;
  // Boot sector content; the top byte holds only the debug read permission
  function automatic logic [7:0] fbyte(input logic [13:0] a);
    return (a == 14'h3FFF) ? {prot_bit_in, 7'h00} : (a[7:0] ^ {2'h0, a[13:8]});
  endfunction : fbyte
  // Quick answers, slow on every sixteenth byte; a fresh request replaces an old one
  always_ff @(posedge core_clk_in) begin
    flash_rvalid_out <= 1'b0;
    flash_rdata_out  <= ~flash_rdata_out; // Idle data bus inverts every cycle, so a stale byte is never held steady
    if (!resetn_in) begin
      busy_q          <= 1'b0;
      flash_rdata_out <= 8'h5A;
    end else if (flash_rd_in) begin
      addr_q <= flash_addr_in;
      wait_q <= 2'h2;
      busy_q <= (flash_addr_in[3:0] == 4'hF);
      if (flash_addr_in[3:0] != 4'hF) begin
        flash_rvalid_out <= 1'b1;
        flash_rdata_out  <= fbyte(flash_addr_in);
      end
    end else if (busy_q && wait_q != 2'h0) begin
      wait_q <= wait_q - 2'h1;
    end else if (busy_q) begin
      busy_q           <= 1'b0;
      flash_rvalid_out <= 1'b1;
      flash_rdata_out  <= fbyte(addr_q);
    end
  end
  // SRAM stalls one cycle in five so the loader must hold its write
  assign sram_ready_out = (stall_q != 3'h0);
  always_ff @(posedge core_clk_in) begin
    stall_q <= (!resetn_in || stall_q == 3'h4) ? 3'h0 : stall_q + 3'h1;
    if (sram_we_in && sram_ready_out) begin
      sram_mem[sram_waddr_in] <= sram_wdata_in;
    end
  end
endmodule : bmr_far_model

/* tb/boot_mirror_remap_control_bench.sv */
// Self-checking bench: copy and release, registers, routing, soft reset and reboot.
// Assumes the far-side model for flash and SRAM, and the bound checker.
`timescale 1ns/10ps
`include "bmr_cfg.svh"
module boot_mirror_remap_control_bench;
  import bmr_pkg::*;
  localparam logic [11:0] CTRL_A = {`BMR_CTRL_IDX, 2'b00};
  localparam logic [11:0] STAT_A = {`BMR_STAT_IDX, 2'b00};
  logic        core_clk_in = 1'b0, resetn_in = 1'b0, prot_bit = 1'b1;
  logic        psel_in = 1'b0, penable_in = 1'b0, pwrite_in = 1'b0, pready_out, pslverr_out;
  logic [11:0] paddr_in = 12'h000;
  logic [31:0] pwdata_in = 32'h0, prdata_out;
  logic        ldr_flash_rd_out, flash_rvalid_in, sram_we_out, sram_ready_in;
  logic [13:0] ldr_flash_addr_out, sram_waddr_out;
  logic [7:0]  flash_rdata_in, sram_wdata_out;
  logic [18:0] cpu_paddr_in = 19'h0, cpu_flash_addr_out;
  logic        cpu_sram_sel_out, cpu_flash_sel_out, dbg_flash_rd_in = 1'b0, dbg_flash_rd_ok_out;
  logic        cpu_hold_out, periph_reset_out, eeprom_reload_out, eeprom_boot_disable_in = 1'b0;
  logic [1:0]  clock_strap_pins_in = 2'h0;
  logic [31:0] d;
  logic        e;
  int          failures = 0, tests_run = 0;
  // ****************************************************************
  // Design, far side, clock
  // ****************************************************************
  bmr_boot_mirror #(.LOAD_BUDGET_CYC(200)) dut_u (.clk_en_in(1'b1), .*);
  bmr_far_model far_u (.core_clk_in(core_clk_in), .resetn_in(resetn_in), .prot_bit_in(prot_bit),
    .flash_rd_in(ldr_flash_rd_out), .flash_addr_in(ldr_flash_addr_out),
    .flash_rvalid_out(flash_rvalid_in), .flash_rdata_out(flash_rdata_in),
    .sram_we_in(sram_we_out), .sram_waddr_in(sram_waddr_out), .sram_wdata_in(sram_wdata_out),
    .sram_ready_out(sram_ready_in));
  initial begin
    forever #25 core_clk_in = ~core_clk_in;
  end
  // ****************************************************************
  // Shared tasks
  // ****************************************************************
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      failures++;
      $display("wrong value at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask : check
  task automatic end_of_test();
    $display("comparisons %0d, mismatches %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : end_of_test
  // One APB transfer; the request stands until pready is seen at an edge
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
    int n;
    @(posedge core_clk_in);
    psel_in   <= 1'b1;
    pwrite_in <= wr;
    paddr_in  <= a;
    pwdata_in <= wd;
    @(posedge core_clk_in);
    penable_in <= 1'b1;
    n = 0;
    do begin
      @(posedge core_clk_in);
      n++;
    end while (pready_out !== 1'b1 && n < 20);
    d = prdata_out;
    e = pslverr_out;
    psel_in    <= 1'b0;
    penable_in <= 1'b0;
    if (pready_out !== 1'b1) begin
      failures++;
      end_of_test();
    end
  endtask : apb
  // ****************************************************************
  // Scenarios
  // ****************************************************************
  // Copy runs with the CPU held, then SRAM, status and debug gate agree with the sector
  task automatic t_boot(input logic p);
    int a;
    check(cpu_hold_out, 1'b1);
    a = 0;
    while (cpu_hold_out !== 1'b0 && a < 60000) begin
      @(posedge core_clk_in);
      a++;
    end
    check(cpu_hold_out, 1'b0);
    if (cpu_hold_out !== 1'b0) end_of_test();
    for (a = 0; a < 16383; a += 1021) begin
      check(far_u.sram_mem[a], a[7:0] ^ {2'h0, a[13:8]});
    end
    check(far_u.sram_mem[16383], {p, 7'h00});
    apb(1'b0, STAT_A, 32'h0);
    check(d, {28'h0, 1'b1, p, 2'b10});
    @(posedge core_clk_in);
    check(dbg_flash_rd_ok_out, p);
  endtask : t_boot
  // Strap and boot-skip mirrors for every code, bit 4 reads 0, refused accesses
  task automatic t_regs();
    for (int i = 0; i < 8; i++) begin
      clock_strap_pins_in    <= i[1:0];
      eeprom_boot_disable_in <= i[2];
      repeat (3) @(posedge core_clk_in);
      apb(1'b0, CTRL_A, 32'h0);
      check(d, {24'h0, i[1:0], i[2], 5'h00});
    end
    apb(1'b1, CTRL_A, 32'h14);
    apb(1'b1, CTRL_A + 12'h1, 32'h0);
    check(e, 1'b1);
    apb(1'b0, 12'h100, 32'h0);
    check({e, d}, {1'b1, 32'h0});
    apb(1'b0, CTRL_A, 32'h0);
    check(d, 32'hE4);
  endtask : t_regs
  // Program addresses across both boundaries, remap on or off
  task automatic t_route(input logic rm);
    logic [18:0] tbl [5] = '{19'h00123, 19'h03FFF, 19'h04000, 19'h07ABC, 19'h09000};
    foreach (tbl[i]) begin
      cpu_paddr_in <= tbl[i];
      @(posedge core_clk_in);
      check({cpu_sram_sel_out, cpu_flash_sel_out}, tbl[i] < 19'h04000 ? 2'b10 : 2'b01);
      if (tbl[i] >= 19'h04000) begin
        check(cpu_flash_addr_out, (rm && tbl[i] < 19'h08000) ? tbl[i] - 19'h04000 : tbl[i]);
      end
    end
  endtask : t_route
  // Soft reset pulses once and reads back clear, remap kept
  task automatic t_soft();
    apb(1'b1, CTRL_A, 32'h5);
    @(negedge core_clk_in);
    check({periph_reset_out, eeprom_reload_out}, 2'b10);
    @(negedge core_clk_in);
    check(periph_reset_out, 1'b0);
    apb(1'b0, CTRL_A, 32'h0);
    check(d[2:0], 3'b100);
  endtask : t_soft
  // Reboot with a protected sector, a second reboot in mid-copy, then a full copy
  task automatic t_reboot();
    prot_bit <= 1'b0;
    apb(1'b1, CTRL_A, 32'h2);
    @(negedge core_clk_in);
    check({periph_reset_out, eeprom_reload_out}, 2'b11);
    repeat (100) @(posedge core_clk_in);
    apb(1'b0, STAT_A, 32'h0);
    check(d[1:0], 2'b01);
    apb(1'b1, CTRL_A, 32'h2);
    t_boot(1'b0);
    apb(1'b0, CTRL_A, 32'h0);
    check(d[4:0], 5'h00);
    t_route(1'b0);
  endtask : t_reboot
  // Reset held two cycles, then the scenarios in order
  initial begin
    repeat (2) @(posedge core_clk_in);
    resetn_in       <= 1'b1;
    dbg_flash_rd_in <= 1'b1;
    t_boot(1'b1);
    t_regs();
    t_route(1'b1);
    t_soft();
    t_reboot();
    end_of_test();
  end
endmodule : boot_mirror_remap_control_bench
